// >>> core/fan_speed_control.sv
// Fan output control bank: registers, automatic fan control and PWM/DC drive.
//
// Function
// - PWM duty is value/256 per period; FFh is full on, 00h off.
// - DC drive level is the value's upper six bits; low two ignored.
// - Config one bit 1 picks PWM or DC for processor output; reset PWM.
// - Config one bit 0 picks PWM or DC for system output; reset DC.
// - Config one bits 5-4 pick processor mode: manual, thermal, speed, adaptive.
// - Config one bits 3-2 pick system mode; code 11 does nothing.
// - System target is 7-bit temperature or 8-bit tach speed.
// - Processor target is 7-bit temperature or 8-bit tach speed.
// - Tolerance register: processor in upper nibble, system in lower nibble.
// - Thermal cruise lowers system output to its stop value; software keeps it non-zero.
// - Processor output uses its stop floor in thermal and adaptive modes.
// - Starting from zero, thermal cruise jumps to the start-up value first.
// - Stop time holds the stop value before zero; unit 0.1 s or 0.4 s.
// - Step down time spaces decrements; unit 0.1 s or 0.4 s.
// - Step up time spaces increments; unit 0.1 s or 0.4 s.
// - Aux frequency bit 7 selects a 24 MHz or 180 kHz source.
// - Aux PWM rate is source / divider / 256; divider zero is not allowed.
// - Aux value gives PWM duty, or a DC level when config two bit 0 set.
// - Config two bits 5-3 choose holding the floor or decaying to zero.
// - Config two bits 2-1 pick aux mode; code 11 does nothing.
// - Config two bit 0 picks PWM or DC for aux output; reset PWM.
// - Index written to address port selects the register the data port moves.
`timescale 1ns/1ps
module fan_speed_control
  import fan_speed_control_pkg::*;
#(
  parameter int unsigned P_STEP_UNIT_CYCLES = STEP_UNIT_CYCLES
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Index and data port.
  input wire logic i_port_sel,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Measurements from the monitor core.
  input wire logic [7:0] i_system_temp_input,
  input wire logic [7:0] i_proc_temp_input,
  input wire logic [7:0] i_aux_temp_input,
  input wire logic [7:0] i_system_tach_input,
  input wire logic [7:0] i_proc_tach_input_a,
  input wire logic [7:0] i_aux_tach_input,
  // Auxiliary output settings held elsewhere in the bank.
  input wire logic [7:0] i_aux_target,
  input wire logic [3:0] i_aux_tolerance,
  input wire logic [7:0] i_aux_stop_value,
  input wire logic [7:0] i_aux_startup_value,
  input wire logic [7:0] i_aux_stop_time,
  // Fan outputs: system, processor A, auxiliary.
  output logic [NUM_CH-1:0] o_fan_pwm,
  output logic [NUM_CH-1:0] o_fan_dc,
  output logic [NUM_CH-1:0][5:0] o_fan_level
);

  localparam logic [TICK_CNT_W-1:0] TENTH_LAST = TICK_CNT_W'(P_STEP_UNIT_CYCLES - 1);
  localparam state_s RESET_STATE = '{regs: REG_RESET, default: '0};

  state_s q;
  state_s d;
  logic tick;
  logic tick4;
  logic fast_en;
  logic slow_en;
  logic [NUM_CH-1:0][7:0] meas_temp;
  logic [NUM_CH-1:0][7:0] meas_tach;
  logic [NUM_CH-1:0][7:0] target;
  logic [NUM_CH-1:0][3:0] tol;
  logic [NUM_CH-1:0][7:0] stop_value;
  logic [NUM_CH-1:0][7:0] startup_value;
  logic [NUM_CH-1:0][7:0] stop_time;
  logic [NUM_CH-1:0] floor_hold;

  function automatic mode_e ch_mode(input logic [NUM_REGS-1:0][7:0] r, input int unsigned c);
    mode_e m;
    m = MODE_MANUAL;
    unique case (c)
      CH_SYS: m = mode_e'(r[IDX_CFG1][CFG1_SYS_MODE +: 2]);
      CH_PROC: m = mode_e'(r[IDX_CFG1][CFG1_PROC_MODE +: 2]);
      default: m = mode_e'(r[IDX_CFG2][CFG2_AUX_MODE +: 2]);
    endcase
    return m;
  endfunction : ch_mode

  function automatic logic ch_dc(input logic [NUM_REGS-1:0][7:0] r, input int unsigned c);
    logic dc;
    dc = 1'b0;
    unique case (c)
      CH_SYS: dc = r[IDX_CFG1][CFG1_SYS_DC];
      CH_PROC: dc = r[IDX_CFG1][CFG1_PROC_DC];
      default: dc = r[IDX_CFG2][CFG2_AUX_DC];
    endcase
    return dc;
  endfunction : ch_dc

  function automatic logic [7:0] sat_inc(input logic [7:0] x);
    return (x == 8'hFF) ? x : x + 8'h01;
  endfunction : sat_inc

  assign meas_temp[CH_SYS] = i_system_temp_input;
  assign meas_temp[CH_PROC] = i_proc_temp_input;
  assign meas_temp[CH_AUX] = i_aux_temp_input;
  assign meas_tach[CH_SYS] = i_system_tach_input;
  assign meas_tach[CH_PROC] = i_proc_tach_input_a;
  assign meas_tach[CH_AUX] = i_aux_tach_input;
  assign target[CH_SYS] = q.regs[IDX_SYS_TARGET];
  assign target[CH_PROC] = q.regs[IDX_PROC_TARGET];
  assign target[CH_AUX] = i_aux_target;
  assign tol[CH_SYS] = q.regs[IDX_TOLERANCE][TOL_SYS_LSB +: 4];
  assign tol[CH_PROC] = q.regs[IDX_TOLERANCE][TOL_PROC_LSB +: 4];
  assign tol[CH_AUX] = i_aux_tolerance;
  assign stop_value[CH_SYS] = q.regs[IDX_SYS_STOP_VALUE];
  assign stop_value[CH_PROC] = q.regs[IDX_PROC_STOP_VALUE];
  assign stop_value[CH_AUX] = i_aux_stop_value;
  assign startup_value[CH_SYS] = q.regs[IDX_SYS_STARTUP];
  assign startup_value[CH_PROC] = q.regs[IDX_PROC_STARTUP];
  assign startup_value[CH_AUX] = i_aux_startup_value;
  assign stop_time[CH_SYS] = q.regs[IDX_SYS_STOP_TIME];
  assign stop_time[CH_PROC] = q.regs[IDX_PROC_STOP_TIME];
  assign stop_time[CH_AUX] = i_aux_stop_time;
  assign floor_hold[CH_SYS] = q.regs[IDX_CFG2][CFG2_FLOOR_SYS];
  assign floor_hold[CH_PROC] = q.regs[IDX_CFG2][CFG2_FLOOR_PROC];
  assign floor_hold[CH_AUX] = q.regs[IDX_CFG2][CFG2_FLOOR_AUX];

  always_comb begin
    mode_e mode;
    logic dc;
    logic unit;
    logic thermal;
    logic speed;
    logic more;
    logic less;
    logic at_floor;
    logic [7:0] value;
    logic [7:0] nv;
    logic [7:0] freq;
    logic [6:0] div_last;
    logic [8:0] meas9;
    logic [8:0] targ9;
    logic [8:0] tol9;
    mode = MODE_MANUAL;
    dc = 1'b0;
    unit = 1'b0;
    thermal = 1'b0;
    speed = 1'b0;
    more = 1'b0;
    less = 1'b0;
    at_floor = 1'b0;
    value = 8'h00;
    nv = 8'h00;
    freq = 8'h00;
    div_last = 7'h00;
    meas9 = 9'h000;
    targ9 = 9'h000;
    tol9 = 9'h000;
    d = q;

    // tenth-second base and four-tenth base for DC units
    tick = (q.tenth_cnt == TENTH_LAST);
    d.tenth_cnt = tick ? '0 : q.tenth_cnt + TICK_CNT_W'(1);
    if (tick) begin
      d.quarter = q.quarter + 2'h1;
    end
    tick4 = tick && (q.quarter == QUARTER_LAST);

    fast_en = (q.acc_fast >= FAST_MOD - FAST_INC);
    d.acc_fast = fast_en ? q.acc_fast + FAST_INC - FAST_MOD : q.acc_fast + FAST_INC;
    slow_en = (q.acc_slow >= SLOW_MOD - SLOW_INC);
    d.acc_slow = slow_en ? q.acc_slow + SLOW_INC - SLOW_MOD : q.acc_slow + SLOW_INC;

    for (int unsigned c = 0; c < NUM_CH; c++) begin
      value = q.regs[CH_VALUE_IDX[c]];
      dc = ch_dc(q.regs, c);
      mode = ch_mode(q.regs, c);
      unit = dc ? tick4 : tick;

      freq = (c == CH_AUX) ? q.regs[IDX_AUX_FREQ] : FIXED_FREQ;
      div_last = (freq[6:0] == 7'h00) ? 7'h00 : freq[6:0] - 7'h01;
      if (freq[FREQ_SRC_BIT] ? slow_en : fast_en) begin
        if (q.pre_cnt[c] >= div_last) begin
          d.pre_cnt[c] = 7'h00;
          d.pwm_cnt[c] = q.pwm_cnt[c] + 8'h01;
          if (q.pwm_cnt[c] == 8'hFF) begin
            d.duty[c] = value;
          end
        end else begin
          d.pre_cnt[c] = q.pre_cnt[c] + 7'h01;
        end
      end
      d.pwm[c] = !dc && ((q.duty[c] == DUTY_FULL) || (q.pwm_cnt[c] < q.duty[c]));
      // DC level from upper six bits
      d.level[c] = dc ? value[7:2] : 6'h00;

      // thermal floor in adaptive mode too, processor output only
      unique case (mode)
        MODE_THERMAL: thermal = 1'b1;
        MODE_ADAPTIVE: thermal = (c == CH_PROC);
        default: thermal = 1'b0;
      endcase
      speed = (mode == MODE_SPEED);
      tol9 = {5'h00, tol[c]};
      if (thermal) begin
        meas9 = {1'b0, meas_temp[c]};
        targ9 = {2'b00, target[c][6:0]};
      end else begin
        meas9 = {1'b0, meas_tach[c]};
        targ9 = {1'b0, target[c]};
      end
      more = (thermal || speed) && (meas9 > targ9 + tol9);
      less = (thermal || speed) && (meas9 + tol9 < targ9);

      // hold at stop value while too cool
      at_floor = thermal && less && (value != 8'h00) && (value <= stop_value[c]);
      if (!at_floor) begin
        d.stop_cnt[c] = 8'h00;
      end
      if (thermal || speed) begin
        if (unit) begin
          d.step_cnt[c] = sat_inc(q.step_cnt[c]);
        end
      end else begin
        d.step_cnt[c] = 8'h00;
      end

      nv = value;
      if (more && unit && (q.step_cnt[c] >= q.regs[IDX_STEP_UP])) begin
        d.step_cnt[c] = 8'h00;
        // jump to start-up value from zero
        if (thermal && (value == 8'h00)) begin
          nv = startup_value[c];
        end else begin
          nv = sat_inc(value);
        end
      end else if (at_floor && unit) begin
        // floor bit keeps the stop value
        if (!floor_hold[c]) begin
          d.stop_cnt[c] = sat_inc(q.stop_cnt[c]);
          // drop to zero after stop time
          if (q.stop_cnt[c] >= stop_time[c]) begin
            nv = 8'h00;
            d.stop_cnt[c] = 8'h00;
          end
        end
      end else if (less && unit && (q.step_cnt[c] >= q.regs[IDX_STEP_DOWN]) && (value != 8'h00)) begin
        d.step_cnt[c] = 8'h00;
        nv = value - 8'h01;
      end
      d.regs[CH_VALUE_IDX[c]] = nv;
    end

    if (i_wr) begin
      if (!i_port_sel) begin
        d.index = i_wdata[6:0];
      end else if (q.index <= IDX_LAST) begin
        d.regs[q.index[4:0]] = i_wdata & REG_WMASK[q.index[4:0]];
      end
    end
    if (i_rd) begin
      if (!i_port_sel) begin
        d.rdata = {1'b0, q.index};
      end else if (q.index <= IDX_LAST) begin
        d.rdata = q.regs[q.index[4:0]];
      end else begin
        d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_fan_pwm = q.pwm;
  assign o_fan_level = q.level;
  // aux drive type from config two
  assign o_fan_dc = {q.regs[IDX_CFG2][CFG2_AUX_DC], q.regs[IDX_CFG1][CFG1_PROC_DC],
                     q.regs[IDX_CFG1][CFG1_SYS_DC]};

endmodule : fan_speed_control

// >>> core/fan_speed_control_pkg.sv
// Constants, register map and state layout of the fan output control bank.
package fan_speed_control_pkg;

  // Clock and step timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STEP_UNIT_NS = 100_000_000;
  localparam int unsigned STEP_UNIT_CYCLES = STEP_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned DC_UNIT_TENTHS = 4;
  localparam logic [1:0] QUARTER_LAST = 2'(DC_UNIT_TENTHS - 1);
  localparam int unsigned TICK_CNT_W = 24;

  // PWM source clocks made from the core clock by phase accumulators.
  localparam logic [6:0] FAST_INC = 7'h18;
  localparam logic [6:0] FAST_MOD = 7'h64;
  localparam logic [16:0] SLOW_INC = 17'h000B4;
  localparam logic [16:0] SLOW_MOD = 17'h186A0;

  // Register indices on the data port.
  localparam logic [6:0] IDX_SYS_VALUE = 7'h01;
  localparam logic [6:0] IDX_PROC_VALUE = 7'h03;
  localparam logic [6:0] IDX_CFG1 = 7'h04;
  localparam logic [6:0] IDX_SYS_TARGET = 7'h05;
  localparam logic [6:0] IDX_PROC_TARGET = 7'h06;
  localparam logic [6:0] IDX_TOLERANCE = 7'h07;
  localparam logic [6:0] IDX_SYS_STOP_VALUE = 7'h08;
  localparam logic [6:0] IDX_PROC_STOP_VALUE = 7'h09;
  localparam logic [6:0] IDX_SYS_STARTUP = 7'h0A;
  localparam logic [6:0] IDX_PROC_STARTUP = 7'h0B;
  localparam logic [6:0] IDX_SYS_STOP_TIME = 7'h0C;
  localparam logic [6:0] IDX_PROC_STOP_TIME = 7'h0D;
  localparam logic [6:0] IDX_STEP_DOWN = 7'h0E;
  localparam logic [6:0] IDX_STEP_UP = 7'h0F;
  localparam logic [6:0] IDX_AUX_FREQ = 7'h10;
  localparam logic [6:0] IDX_AUX_VALUE = 7'h11;
  localparam logic [6:0] IDX_CFG2 = 7'h12;
  localparam logic [6:0] IDX_LAST = 7'h12;
  localparam int unsigned NUM_REGS = 19;

  // Field positions.
  localparam int unsigned CFG1_SYS_DC = 0;
  localparam int unsigned CFG1_PROC_DC = 1;
  localparam int unsigned CFG1_SYS_MODE = 2;
  localparam int unsigned CFG1_PROC_MODE = 4;
  localparam int unsigned CFG2_AUX_DC = 0;
  localparam int unsigned CFG2_AUX_MODE = 1;
  localparam int unsigned CFG2_FLOOR_AUX = 3;
  localparam int unsigned CFG2_FLOOR_PROC = 4;
  localparam int unsigned CFG2_FLOOR_SYS = 5;
  localparam int unsigned FREQ_SRC_BIT = 7;
  localparam int unsigned TOL_PROC_LSB = 4;
  localparam int unsigned TOL_SYS_LSB = 0;
  localparam logic [7:0] FIXED_FREQ = 8'h04;
  localparam logic [7:0] DUTY_FULL = 8'hFF;

  // Reset values and writable bits, fan_config_two first.
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
    8'h00, 8'hFF, 8'h04, 8'h0A, 8'h0A, 8'h3C, 8'h3C, 8'h01, 8'h01, 8'h01,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h00, 8'hFF, 8'h00};
  localparam logic [NUM_REGS-1:0][7:0] REG_WMASK = {
    8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h00, 8'hFF, 8'h00};

  // Fan outputs.
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned CH_SYS = 0;
  localparam int unsigned CH_PROC = 1;
  localparam int unsigned CH_AUX = 2;
  localparam logic [NUM_CH-1:0][6:0] CH_VALUE_IDX = {IDX_AUX_VALUE, IDX_PROC_VALUE, IDX_SYS_VALUE};

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_THERMAL = 2'b01,
    MODE_SPEED = 2'b10,
    MODE_ADAPTIVE = 2'b11
  } mode_e;

  typedef struct packed {
    logic [6:0] index;
    logic [7:0] rdata;
    logic [NUM_REGS-1:0][7:0] regs;
    logic [TICK_CNT_W-1:0] tenth_cnt;
    logic [1:0] quarter;
    logic [6:0] acc_fast;
    logic [16:0] acc_slow;
    logic [NUM_CH-1:0][6:0] pre_cnt;
    logic [NUM_CH-1:0][7:0] pwm_cnt;
    logic [NUM_CH-1:0][7:0] duty;
    logic [NUM_CH-1:0][7:0] step_cnt;
    logic [NUM_CH-1:0][7:0] stop_cnt;
    logic [NUM_CH-1:0] pwm;
    logic [NUM_CH-1:0][5:0] level;
  } state_s;

endpackage : fan_speed_control_pkg

// >>> test/fan_speed_control_chk.sv
// Port checker for the fan output control bank.
`timescale 1ns/1ps
module fan_speed_control_chk
  import fan_speed_control_pkg::*;
#(
  parameter int unsigned P_STEP_UNIT_CYCLES = STEP_UNIT_CYCLES
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Register port.
  input wire logic i_port_sel,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  // Fan outputs.
  input wire logic [NUM_CH-1:0] o_fan_pwm,
  input wire logic [NUM_CH-1:0] o_fan_dc,
  input wire logic [NUM_CH-1:0][5:0] o_fan_level
);
  typedef struct packed {
    logic [6:0] idx;
    logic [7:0] cfg1;
  } shadow_s;
  shadow_s s_q;
  shadow_s s_d;
  logic wd;
  assign wd = i_wr && i_port_sel;
  always_comb begin
    s_d = s_q;
    if (i_wr && !i_port_sel) s_d.idx = i_wdata[6:0];
    if (wd && s_q.idx == IDX_CFG1) s_d.cfg1 = i_wdata & 8'h3F;
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) s_q <= {7'h00, 8'h01};
    else s_q <= s_d;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence sys_val_wr;
    wd && s_q.idx == IDX_SYS_VALUE && o_fan_dc[0] && s_q.cfg1[3] == s_q.cfg1[2];
  endsequence
  AST_IDX_READ: assert property (i_rd && !i_port_sel |=> o_rdata == {1'b0, $past(s_q.idx)})
    else $error("index read wrong");
  AST_RD_HOLD: assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data moved");
  AST_RD_UNMAPPED: assert property (i_rd && i_port_sel && s_q.idx > IDX_LAST |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CFG1_READ: assert property (i_rd && i_port_sel && s_q.idx == IDX_CFG1 |=> o_rdata == $past(s_q.cfg1))
    else $error("config one read wrong");
  AST_DC_CFG1: assert property (o_fan_dc[1:0] == s_q.cfg1[1:0])
    else $error("drive type one wrong");
  AST_DC_CFG2: assert property (wd && s_q.idx == IDX_CFG2 |=> o_fan_dc[2] == $past(i_wdata[0]))
    else $error("aux drive type wrong");
  AST_PWM_LOW_DC: assert property ((o_fan_dc & $past(o_fan_dc) & o_fan_pwm) == 3'b000)
    else $error("pwm active in dc drive");
  AST_LEVEL_PWM: assert property (!o_fan_dc[1] && !$past(o_fan_dc[1]) |-> o_fan_level[1] == 6'h00)
    else $error("level set in pwm drive");
  AST_MANUAL_LEVEL: assert property (sys_val_wr ##1 !wd |=> o_fan_level[0] == $past(i_wdata[7:2], 2))
    else $error("manual level wrong");
  COV_IDX_READ: cover property (i_rd && !i_port_sel);
  COV_AUX_PWM: cover property ($rose(o_fan_pwm[2]));
  COV_DC_LEVEL: cover property (o_fan_dc[0] && o_fan_level[0] != 6'h00);
endmodule : fan_speed_control_chk

bind fan_speed_control fan_speed_control_chk #(.P_STEP_UNIT_CYCLES(P_STEP_UNIT_CYCLES)) chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_port_sel(i_port_sel), .i_wr(i_wr), .i_rd(i_rd),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .o_fan_pwm(o_fan_pwm), .o_fan_dc(o_fan_dc),
  .o_fan_level(o_fan_level)
);

// >>> test/fan_model.sv
// Fan model that turns each drive into a tachometer count.
`timescale 1ns/1ps
module fan_model
  import fan_speed_control_pkg::*;
(
  // Clock.
  input wire logic i_clk,
  // Drives.
  input wire logic [NUM_CH-1:0] i_pwm,
  input wire logic [NUM_CH-1:0] i_dc,
  input wire logic [NUM_CH-1:0][5:0] i_level,
  // Tachometer counts, larger means slower.
  output logic [NUM_CH-1:0][7:0] o_tach
);
  logic [NUM_CH-1:0][7:0] spin = '0;
  always @(negedge i_clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (i_dc[c]) spin[c] <= {i_level[c], 2'b00};
      else if (i_pwm[c] && spin[c] != 8'hFF) spin[c] <= spin[c] + 8'h01;
      else if (!i_pwm[c] && spin[c] != 8'h00) spin[c] <= spin[c] - 8'h01;
    end
  end
  assign o_tach = ~spin;
endmodule : fan_model

// >>> test/fan_speed_control_test.sv
// Self-checking bench for the fan output control bank.
`timescale 1ns/1ps
module fan_speed_control_test;
  import fan_speed_control_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [NUM_CH-1:0][7:0] temp = '0;
  logic [NUM_CH-1:0][7:0] tach;
  logic [35:0] aux = '0;
  logic [NUM_CH-1:0] pwm;
  logic [NUM_CH-1:0] dc;
  logic [NUM_CH-1:0][5:0] lvl;
  logic [31:0] seed = 32'h6A99;
  int err_count = 0;
  int comparisons = 0;
  always #5 i_clk = ~i_clk;
  fan_speed_control #(.P_STEP_UNIT_CYCLES(4)) dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_port_sel(sel), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdata), .o_rdata(rdata), .i_system_temp_input(temp[0]),
    .i_proc_temp_input(temp[1]), .i_aux_temp_input(temp[2]), .i_system_tach_input(tach[0]),
    .i_proc_tach_input_a(tach[1]), .i_aux_tach_input(tach[2]), .i_aux_target(aux[7:0]),
    .i_aux_tolerance(aux[11:8]), .i_aux_stop_value(aux[19:12]),
    .i_aux_startup_value(aux[27:20]), .i_aux_stop_time(aux[35:28]),
    .o_fan_pwm(pwm), .o_fan_dc(dc), .o_fan_level(lvl)
  );
  fan_model fans (.i_clk(i_clk), .i_pwm(pwm), .i_dc(dc), .i_level(lvl), .o_tach(tach));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] rst_val(input logic [6:0] i);
    case (i)
      7'h01, 7'h03, 7'h11: return 8'hFF;
      7'h04, 7'h08, 7'h09, 7'h0A, 7'h0B: return 8'h01;
      7'h0C, 7'h0D: return 8'h3C;
      7'h0E, 7'h0F: return 8'h0A;
      7'h10: return 8'h04;
      default: return 8'h00;
    endcase
  endfunction : rst_val
  function automatic logic [7:0] wmask(input logic [6:0] i);
    if (i == 7'h00 || i == 7'h02 || i > 7'h12) return 8'h00;
    if (i == 7'h04) return 8'h3F;
    return (i == 7'h12) ? 8'h7F : 8'hFF;
  endfunction : wmask
  function automatic int near(input int a, input int b, input int t);
    return int'(a >= b - t && a <= b + t);
  endfunction : near
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic acc(input logic s, input logic w, input logic [7:0] d);
    @(negedge i_clk);
    sel = s;
    wr = w;
    rd = !w;
    wdata = d;
    @(negedge i_clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask : acc
  task automatic wreg(input logic [6:0] i, input logic [7:0] d);
    acc(1'b0, 1'b1, {1'b0, i});
    acc(1'b1, 1'b1, d);
  endtask : wreg
  task automatic rreg(input logic [6:0] i);
    acc(1'b0, 1'b1, {1'b0, i});
    acc(1'b1, 1'b0, 8'h00);
  endtask : rreg
  task automatic poll(input logic [6:0] i, input logic [7:0] v);
    rreg(i);
    for (int n = 0; n < 60 && rdata !== v; n++) rreg(i);
    chk("poll", rdata, v);
    if (rdata !== v) print_verdict();
  endtask : poll
  task automatic span(input int c, input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(negedge i_clk);
      hi += pwm[c];
    end
  endtask : span
  task automatic meas(input int c, output int hi, output int per);
    int ph;
    logic p;
    ph = 0;
    p = pwm[c];
    hi = 0;
    per = 0;
    for (int n = 0; n < 9000 && ph < 2; n++) begin
      @(negedge i_clk);
      if (pwm[c] && !p) ph++;
      if (ph == 1) begin
        per++;
        hi += pwm[c];
      end
      p = pwm[c];
    end
    chk("pwm edges", 8'(ph), 8'h02);
    if (ph < 2) print_verdict();
  endtask : meas
  initial begin
    logic [31:0] r;
    logic [6:0] idx;
    logic [7:0] d;
    int hi;
    int per;
    aux = {4'(rnd()), rnd()};
    temp = 24'(rnd());
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_nrst = 1'b1;
    chk("dc reset", 8'(dc), 8'h01);
    for (int i = 0; i < 20; i++) begin
      rreg(7'(i));
      chk("reset", rdata, rst_val(7'(i)));
    end
    acc(1'b0, 1'b0, 8'h00);
    chk("index", rdata, 8'h13);
    for (int k = 0; k < 40; k++) begin
      r = rnd();
      idx = 7'(r[7:0] % 20);
      d = r[15:8];
      if (idx == IDX_CFG1) d &= 8'hC3;
      if (idx == IDX_CFG2) d &= 8'hF9;
      if (idx == IDX_AUX_FREQ) d[0] = 1'b1;
      wreg(idx, d);
      rreg(idx);
      chk("reg rw", rdata, d & wmask(idx));
    end
    wreg(IDX_CFG1, 8'h03);
    wreg(IDX_CFG2, 8'h01);
    for (int c = 0; c < 3; c++) begin
      d = 8'(rnd());
      wreg(CH_VALUE_IDX[c], d);
      @(negedge i_clk);
      chk("level", 8'(lvl[c]), 8'(d[7:2]));
      chk("dc pwm", 8'(pwm[c]), 8'h00);
    end
    wreg(IDX_CFG1, 8'h00);
    wreg(IDX_CFG2, 8'h00);
    for (int j = 0; j < 2; j++) begin
      wreg(IDX_PROC_VALUE, j ? 8'hFF : 8'h00);
      repeat (4400) @(negedge i_clk);
      span(1, 12800, hi);
      chk("proc duty", 8'(hi == (j ? 12800 : 0)), 8'h01);
    end
    for (int j = 1; j < 3; j++) begin
      d = 8'h10 + 8'(rnd() % 224);
      wreg(IDX_AUX_FREQ, 8'(j));
      wreg(IDX_AUX_VALUE, d);
      repeat (2400) @(negedge i_clk);
      meas(2, hi, per);
      chk("aux period", 8'(near(per, j * 3200 / 3, 10)), 8'h01);
      chk("aux duty", 8'(near(hi * 256, d * per, 2560)), 8'h01);
    end
    temp[0] = 8'h40;
    wreg(IDX_SYS_VALUE, 8'h00);
    wreg(IDX_SYS_STOP_VALUE, 8'h18);
    wreg(IDX_SYS_STARTUP, 8'h20);
    wreg(IDX_SYS_STOP_TIME, 8'h05);
    wreg(IDX_STEP_DOWN, 8'h01);
    wreg(IDX_STEP_UP, 8'h10);
    wreg(IDX_SYS_TARGET, 8'h30);
    wreg(IDX_TOLERANCE, 8'h00);
    wreg(IDX_CFG2, 8'h20);
    wreg(IDX_CFG1, 8'h04);
    poll(IDX_SYS_VALUE, 8'h20);
    poll(IDX_SYS_VALUE, 8'h21);
    temp[0] = 8'h10;
    poll(IDX_SYS_VALUE, 8'h18);
    repeat (100) @(negedge i_clk);
    rreg(IDX_SYS_VALUE);
    chk("floor hold", rdata, 8'h18);
    wreg(IDX_CFG2, 8'h00);
    rreg(IDX_SYS_VALUE);
    chk("stop hold", rdata, 8'h18);
    poll(IDX_SYS_VALUE, 8'h00);
    wreg(IDX_SYS_VALUE, 8'hFF);
    wreg(IDX_SYS_TARGET, 8'h80);
    wreg(IDX_TOLERANCE, 8'h08);
    wreg(IDX_CFG1, 8'h09);
    repeat (9000) @(negedge i_clk);
    chk("speed", 8'(tach[0] >= 8'h78 && tach[0] <= 8'h88), 8'h01);
    temp[1] = 8'h50;
    wreg(IDX_CFG1, 8'h3C);
    wreg(IDX_PROC_TARGET, 8'h30);
    wreg(IDX_PROC_STARTUP, 8'h40);
    wreg(IDX_SYS_VALUE, 8'h55);
    wreg(IDX_PROC_VALUE, 8'h00);
    poll(IDX_PROC_VALUE, 8'h40);
    rreg(IDX_SYS_VALUE);
    chk("sys mode 11", rdata, 8'h55);
    print_verdict();
  end
endmodule : fan_speed_control_test
